/* File: dv/pnl_checker.sv */
// Port assertions for the panel switch and differential output block.
`timescale 1ns/1ps
`default_nettype none
`include "pnl_consts.svh"

module pnl_checker #(
    parameter int TICK_CYCLES = 20,
    parameter int MS_CYCLES   = 5,
    parameter int QUAD_GAP    = 4
) (
    input wire logic        clock_i,
    input wire logic        rst_i,
    input wire logic [4:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        pos_preset_o,
    input wire logic        start_o,
    input wire logic        func_pulse_o,
    input wire logic [7:0]  func_code_o,
    input wire logic        led_o,
    input wire logic        diff_channel_a_o,
    input wire logic        diff_channel_b_o,
    input wire logic        diff_oe_o
);
    logic [7:0] mode_q;

    // Shadow of the output mode, because the source of the pair is not visible at the ports.
    always_ff @(posedge clock_i) begin
        if (rst_i)
            mode_q <= `PNL_MODE_QUAD;
        else if (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
                 && avs_address_i == `PNL_REG_DIFF_MODE)
            mode_q <= avs_writedata_i[7:0];
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////////////
    property p_wait_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait low too long");
    property p_wait_ans;
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_wait_ans: assert property (p_wait_ans) else $error("request not answered");
    property p_unmapped;
        avs_read_i && !avs_waitrequest_o && avs_address_i > `PNL_REG_STATUS
            |-> avs_readdata_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_preset; pos_preset_o |-> func_pulse_o && func_code_o == `PNL_FN_PRESET; endproperty
    a_preset: assert property (p_preset) else $error("preset without its code");
    property p_start; start_o |-> func_pulse_o && func_code_o == `PNL_FN_START; endproperty
    a_start: assert property (p_start) else $error("start without its code");
    property p_pulse_one; func_pulse_o |=> !func_pulse_o; endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("switch pulse too long");
    property p_led_rise; $rose(led_o) |-> func_pulse_o; endproperty
    a_led_rise: assert property (p_led_rise) else $error("led lit without pulse");
    property p_oe_off; !diff_oe_o |-> !diff_channel_a_o && !diff_channel_b_o; endproperty
    a_oe_off: assert property (p_oe_off) else $error("pair active while off");
    property p_oe_mode;
        !$past(rst_i) && $past(mode_q) == mode_q
            |-> diff_oe_o == (mode_q inside {`PNL_MODE_QUAD, `PNL_MODE_IO});
    endproperty
    a_oe_mode: assert property (p_oe_mode) else $error("enable wrong for mode");
    // Both phases flipping in one cycle would lose a count at the receiver.
    property p_quad_gray;
        (mode_q == `PNL_MODE_QUAD)[*5]
            |-> !($changed(diff_channel_a_o) && $changed(diff_channel_b_o));
    endproperty
    a_quad_gray: assert property (p_quad_gray) else $error("both phases changed");

    c_preset: cover property (pos_preset_o);
    c_start: cover property (start_o);
    c_status: cover property (mode_q == `PNL_MODE_IO && diff_channel_a_o);
endmodule

bind pnl_top pnl_checker #(.TICK_CYCLES(TICK_CYCLES), .MS_CYCLES(MS_CYCLES), .QUAD_GAP(QUAD_GAP))
    u_chk (.clock_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .pos_preset_o, .start_o,
    .func_pulse_o, .func_code_o, .led_o, .diff_channel_a_o, .diff_channel_b_o, .diff_oe_o);
`default_nettype wire

/* File: dv/pnl_quad_rx.sv */
// Model of the external counter that tracks position from the phase pair.
`timescale 1ns/1ps
`default_nettype none

module pnl_quad_rx (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        a_i,
    input  wire logic        b_i,
    input  wire logic        oe_i,
    output logic      [31:0] count_o
);
    logic [1:0] phase_q;
    logic [1:0] phase_d;
    logic [1:0] step;

    // A step of two phases is ambiguous, so it is not counted and is dropped without any flag.
    assign phase_d = {b_i, a_i ^ b_i};
    assign step    = phase_d - phase_q;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            phase_q <= 2'h0;
            count_o <= 32'h0;
        end else if (oe_i) begin
            phase_q <= phase_d;
            if (step == 2'h1)
                count_o <= count_o + 32'h1;
            else if (step == 2'h3)
                count_o <= count_o - 32'h1;
        end
    end
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking testbench for the panel switch and differential output block.
`timescale 1ns/1ps
`default_nettype none
`include "pnl_consts.svh"

module testbench;
    localparam int QG = 4;
    localparam logic [31:0] RST_TAB [7] = '{32'h0000_0009, 32'h000A_1E0A, 32'h0000_0000,
        32'h0000_8080, 32'h0000_0000, 32'h0000_0080, 32'h0000_0000};

    logic         clock_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic         panel_switch_input_i, pos_preset_o, start_o, func_pulse_o, led_o;
    logic         diff_channel_a_o, diff_channel_b_o, diff_oe_o;
    logic [4:0]   avs_address_i;
    logic [7:0]   func_code_o;
    logic [31:0]  avs_writedata_i, avs_readdata_o, feedback_pos_i, rx_count, pos, seen_ev;
    logic [127:0] io_status_i;
    logic [31:0]  rd_q[$];
    logic [31:0]  ev_q[$];
    int           errors;
    int           n_compared;

    pnl_top #(.TICK_CYCLES(20), .MS_CYCLES(5), .QUAD_GAP(QG)) dut (
        .clock_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o, .panel_switch_input_i,
        .feedback_pos_i, .io_status_i, .pos_preset_o, .start_o, .func_pulse_o, .func_code_o,
        .led_o, .diff_channel_a_o, .diff_channel_b_o, .diff_oe_o);
    pnl_quad_rx u_rx (.clock_i, .rst_i, .a_i(diff_channel_a_o), .b_i(diff_channel_b_o),
        .oe_i(diff_oe_o), .count_o(rx_count));

    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] ev(input logic [7:0] code);
        return {21'h0, code == `PNL_FN_PRESET, code == `PNL_FN_START, code, 1'b1};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       input logic [31:0] e);
        int n;
        n = 0;
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_read_i      <= !wr;
        avs_write_i     <= wr;
        if (!wr)
            rd_q.push_back(e);
        do begin
            @(posedge clock_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        if (n >= 20) begin
            errors++;
            close_out();
        end
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic pin(input logic v, input int n);
        panel_switch_input_i <= v;
        repeat (n) @(posedge clock_i);
    endtask

    // Results are matched in order, so a pulse with no note pending fails at once.
    assign seen_ev = {21'h0, pos_preset_o, start_o, func_code_o, led_o};
    always @(posedge clock_i) begin
        if (avs_read_i && avs_waitrequest_o === 1'b0 && rd_q.size() > 0)
            chk(avs_readdata_o, rd_q.pop_front());
        if (func_pulse_o === 1'b1)
            chk(seen_ev, ev_q.size() > 0 ? ev_q.pop_front() : '1);
    end

    initial begin
        repeat (60000) @(posedge clock_i);
        errors++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int i;
        int d;
        logic [6:0] r;
        errors = 0;
        n_compared = 0;
        {rst_i, avs_read_i, avs_write_i, panel_switch_input_i} = 4'h8;
        {avs_address_i, avs_writedata_i, feedback_pos_i, io_status_i, pos} = '0;
        void'($urandom(6));
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        for (i = 0; i < 7; i++)
            bus(1'b0, 5'(4 * i), 32'h0, RST_TAB[i]);
        bus(1'b1, 5'h1C, $urandom, 32'h0);
        bus(1'b0, 5'h1C, 32'h0, 32'h0);
        for (i = 0; i < 6; i++) begin
            d = int'($urandom_range(60)) - 30;
            pos = pos + 32'(d);
            feedback_pos_i <= pos;
            repeat ((d < 0 ? -d : d) * QG + 30) @(posedge clock_i);
            chk(rx_count, pos);
        end
        // Two short presses that together exceed the hold time must not unlock.
        pin(1'b1, 120);
        pin(1'b0, 20);
        pin(1'b1, 120);
        pin(1'b0, 20);
        pin(1'b1, 260);
        pin(1'b0, 20);
        ev_q.push_back(ev(`PNL_FN_PRESET));
        pin(1'b1, 20);
        pin(1'b0, 900);
        pin(1'b1, 50);
        pin(1'b0, 20);
        bus(1'b1, `PNL_REG_SW_CFG, 32'h0000_0101, 32'h0);
        pin(1'b1, 5);
        bus(1'b1, `PNL_REG_SW_TIME, 32'h0003_0000, 32'h0);
        ev_q.push_back(ev(`PNL_FN_START));
        pin(1'b0, 30);
        chk({31'h0, led_o}, 32'h1);
        pin(1'b1, 70);
        chk({31'h0, led_o}, 32'h0);
        ev_q.push_back(ev(`PNL_FN_START));
        pin(1'b0, 10);
        r = 7'($urandom_range(127));
        bus(1'b1, `PNL_REG_DIFF_DLY, 32'h0000_0002, 32'h0);
        bus(1'b1, `PNL_REG_DIFF_SEL, {14'h0, 2'b10, 8'h80, 1'b0, r}, 32'h0);
        bus(1'b1, `PNL_REG_DIFF_MODE, 32'h0000_0008, 32'h0);
        repeat (3) @(posedge clock_i);
        chk({30'h0, diff_channel_a_o, diff_channel_b_o}, 32'h1);
        io_status_i[r] <= 1'b1;
        repeat (3) @(posedge clock_i);
        chk({30'h0, diff_channel_a_o, diff_channel_b_o}, 32'h3);
        io_status_i[r] <= 1'b0;
        repeat (3) @(posedge clock_i);
        chk({30'h0, diff_channel_a_o, diff_channel_b_o}, 32'h3);
        repeat (20) @(posedge clock_i);
        chk({30'h0, diff_channel_a_o, diff_channel_b_o}, 32'h1);
        bus(1'b1, `PNL_REG_DIFF_MODE, 32'h0000_00FF, 32'h0);
        repeat (3) @(posedge clock_i);
        chk({29'h0, diff_oe_o, diff_channel_a_o, diff_channel_b_o}, 32'h0);
        repeat (10) @(posedge clock_i);
        chk(32'(rd_q.size() + ev_q.size()), 32'h0);
        close_out();
    end
endmodule
`default_nettype wire

/* File: src/pnl_consts.svh */
// Constants for the panel switch and differential output block.
`ifndef PNL_CONSTS_SVH
`define PNL_CONSTS_SVH

`define PNL_CLK_NS        25
`define PNL_TICK_NS       100000000
`define PNL_MS_NS         1000000

`define PNL_REG_SW_CFG    5'h00
`define PNL_REG_SW_TIME   5'h04
`define PNL_REG_DIFF_MODE 5'h08
`define PNL_REG_DIFF_SEL  5'h0C
`define PNL_REG_DIFF_DLY  5'h10
`define PNL_REG_STATUS    5'h14

`define PNL_FN_PRESET     8'h09
`define PNL_FN_START      8'h01
`define PNL_SIG_OFF       8'h80

`define PNL_HOLD_RST      6'h0A
`define PNL_RETAIN_RST    6'h1E
`define PNL_LED_RST       6'h0A
`define PNL_MODE_OFF      8'hFF
`define PNL_MODE_QUAD     8'h00
`define PNL_MODE_IO       8'h08

`endif

/* File: src/pnl_pkg.sv */
// Types shared by the panel switch and differential output block.
package pnl_pkg;

    typedef struct packed {
        logic       invert;
        logic [7:0] func;
    } pnl_sw_cfg_t;

    typedef struct packed {
        logic [5:0] led;
        logic [5:0] retain;
        logic [5:0] hold;
    } pnl_sw_time_t;

    typedef struct packed {
        logic       inv_b;
        logic       inv_a;
        logic [7:0] sel_b;
        logic [7:0] sel_a;
    } pnl_diff_sel_t;

    typedef enum logic [1:0] {
        PNL_LOCKED,
        PNL_HOLDING,
        PNL_OPEN
    } pnl_lock_t;

endpackage

/* File: src/pnl_top.sv */
// Panel switch function mapping and differential output source selection.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pnl_consts.svh"

module pnl_top
    import pnl_pkg::*;
#(
    parameter int TICK_CYCLES = `PNL_TICK_NS / `PNL_CLK_NS,
    parameter int MS_CYCLES   = `PNL_MS_NS / `PNL_CLK_NS,
    parameter int QUAD_GAP    = 4
) (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        panel_switch_input_i,
    input  wire logic [31:0] feedback_pos_i,
    input  wire logic [127:0] io_status_i,
    output logic             pos_preset_o,
    output logic             start_o,
    output logic             func_pulse_o,
    output logic      [7:0]  func_code_o,
    output logic             led_o,
    output logic             diff_channel_a_o,
    output logic             diff_channel_b_o,
    output logic             diff_oe_o
);

    ////////////////////////////////////////////////////////////////////////
    // Register file.

    pnl_sw_cfg_t   sw_cfg_q;
    pnl_sw_time_t  sw_time_q;
    logic [7:0]    mode_q;
    pnl_diff_sel_t sel_q;
    logic [15:0]   dly_a_q;
    logic [15:0]   dly_b_q;
    logic [31:0]   status_w;
    logic [31:0]   rdata_w;
    logic          wr_go_w;

    function automatic logic [7:0] pnl_lane(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic       en);
        pnl_lane = en ? new_v : old_v;
    endfunction

    // Waitrequest drops in the cycle after a request appears, so a write
    // lands on the single edge at which the master sees it low.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            avs_waitrequest_o <= 1'b1;
        end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b0;
        end else begin
            avs_waitrequest_o <= 1'b1;
        end
    end

    assign wr_go_w = avs_write_i && !avs_waitrequest_o;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sw_cfg_q  <= '{invert: 1'b0, func: `PNL_FN_PRESET};
            sw_time_q <= '{led: `PNL_LED_RST, retain: `PNL_RETAIN_RST,
                           hold: `PNL_HOLD_RST};
            mode_q    <= `PNL_MODE_QUAD;
            sel_q     <= '{inv_b: 1'b0, inv_a: 1'b0, sel_b: `PNL_SIG_OFF,
                           sel_a: `PNL_SIG_OFF};
            dly_a_q   <= 16'h0000;
            dly_b_q   <= 16'h0000;
        end else if (wr_go_w) begin
            case (avs_address_i)
                `PNL_REG_SW_CFG: begin
                    sw_cfg_q.func <= pnl_lane(sw_cfg_q.func, avs_writedata_i[7:0],
                                              avs_byteenable_i[0]);
                    if (avs_byteenable_i[1]) begin
                        sw_cfg_q.invert <= avs_writedata_i[8];
                    end
                end
                `PNL_REG_SW_TIME: begin
                    if (avs_byteenable_i[0]) begin
                        sw_time_q.hold <= avs_writedata_i[5:0];
                    end
                    if (avs_byteenable_i[1]) begin
                        sw_time_q.retain <= avs_writedata_i[13:8];
                    end
                    if (avs_byteenable_i[2]) begin
                        sw_time_q.led <= avs_writedata_i[21:16];
                    end
                end
                `PNL_REG_DIFF_MODE: begin
                    mode_q <= pnl_lane(mode_q, avs_writedata_i[7:0], avs_byteenable_i[0]);
                end
                `PNL_REG_DIFF_SEL: begin
                    sel_q.sel_a <= pnl_lane(sel_q.sel_a, avs_writedata_i[7:0],
                                            avs_byteenable_i[0]);
                    sel_q.sel_b <= pnl_lane(sel_q.sel_b, avs_writedata_i[15:8],
                                            avs_byteenable_i[1]);
                    if (avs_byteenable_i[2]) begin
                        sel_q.inv_a <= avs_writedata_i[16];
                        sel_q.inv_b <= avs_writedata_i[17];
                    end
                end
                `PNL_REG_DIFF_DLY: begin
                    dly_a_q[7:0]  <= pnl_lane(dly_a_q[7:0], avs_writedata_i[7:0],
                                              avs_byteenable_i[0]);
                    dly_a_q[15:8] <= pnl_lane(dly_a_q[15:8], avs_writedata_i[15:8],
                                              avs_byteenable_i[1]);
                    dly_b_q[7:0]  <= pnl_lane(dly_b_q[7:0], avs_writedata_i[23:16],
                                              avs_byteenable_i[2]);
                    dly_b_q[15:8] <= pnl_lane(dly_b_q[15:8], avs_writedata_i[31:24],
                                              avs_byteenable_i[3]);
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        case (avs_address_i)
            `PNL_REG_SW_CFG:    rdata_w = {23'h0, sw_cfg_q};
            `PNL_REG_SW_TIME:   rdata_w = {10'h0, sw_time_q.led, 2'h0,
                                           sw_time_q.retain, 2'h0, sw_time_q.hold};
            `PNL_REG_DIFF_MODE: rdata_w = {24'h000000, mode_q};
            `PNL_REG_DIFF_SEL:  rdata_w = {14'h0, sel_q};
            `PNL_REG_DIFF_DLY:  rdata_w = {dly_b_q, dly_a_q};
            `PNL_REG_STATUS:    rdata_w = status_w;
            default:            rdata_w = 32'h00000000;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            avs_readdata_o <= 32'h00000000;
        end else if (avs_read_i && avs_waitrequest_o) begin
            avs_readdata_o <= rdata_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Time bases: 0.1 s ticks for the switch, 1 ms ticks for off delays.

    logic [31:0] tick_cnt_q;
    logic [31:0] ms_cnt_q;
    logic        tick_w;
    logic        ms_w;

    assign tick_w = (tick_cnt_q == 32'(TICK_CYCLES - 1));
    assign ms_w   = (ms_cnt_q == 32'(MS_CYCLES - 1));

    always_ff @(posedge clock_i) begin
        if (rst_i || tick_w) begin
            tick_cnt_q <= 32'h00000000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h00000001;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i || ms_w) begin
            ms_cnt_q <= 32'h00000000;
        end else begin
            ms_cnt_q <= ms_cnt_q + 32'h00000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Panel switch: synchroniser, polarity, interlock, function, LED.

    logic      sw_meta_q;
    logic      sw_sync_q;
    logic      pressed_q;
    pnl_lock_t lock_q;
    logic [5:0] hold_cnt_q;
    logic [5:0] retain_cnt_q;
    logic [5:0] led_cnt_q;
    logic      pressed_w;
    logic      fire_w;
    logic      open_w;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sw_meta_q <= 1'b0;
            sw_sync_q <= 1'b0;
            pressed_q <= 1'b0;
        end else begin
            sw_meta_q <= panel_switch_input_i;
            sw_sync_q <= sw_meta_q;
            pressed_q <= pressed_w;
        end
    end

    assign pressed_w = sw_sync_q ^ sw_cfg_q.invert;
    assign open_w    = (sw_time_q.hold == 6'h00) || (lock_q == PNL_OPEN);
    assign fire_w    = pressed_w && !pressed_q && open_w;

    // Hold time counts whole ticks, so a hold can read up to one tick short.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            lock_q       <= PNL_LOCKED;
            hold_cnt_q   <= 6'h00;
            retain_cnt_q <= 6'h00;
        end else begin
            case (lock_q)
                PNL_LOCKED: begin
                    hold_cnt_q <= 6'h00;
                    if (pressed_w && !pressed_q && sw_time_q.hold != 6'h00) begin
                        lock_q <= PNL_HOLDING;
                    end
                end
                PNL_HOLDING: begin
                    if (!pressed_w) begin
                        lock_q     <= PNL_LOCKED;
                        hold_cnt_q <= 6'h00;
                    end else if (hold_cnt_q >= sw_time_q.hold) begin
                        lock_q       <= PNL_OPEN;
                        retain_cnt_q <= sw_time_q.retain;
                    end else if (tick_w) begin
                        hold_cnt_q <= hold_cnt_q + 6'h01;
                    end
                end
                PNL_OPEN: begin
                    if (retain_cnt_q == 6'h00) begin
                        lock_q <= PNL_LOCKED;
                    end else if (tick_w) begin
                        retain_cnt_q <= retain_cnt_q - 6'h01;
                    end
                end
                default: begin
                    lock_q <= PNL_LOCKED;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            func_pulse_o <= 1'b0;
            pos_preset_o <= 1'b0;
            start_o      <= 1'b0;
            func_code_o  <= `PNL_FN_PRESET;
        end else begin
            func_code_o  <= sw_cfg_q.func;
            func_pulse_o <= fire_w;
            pos_preset_o <= fire_w && (sw_cfg_q.func == `PNL_FN_PRESET);
            start_o      <= fire_w && (sw_cfg_q.func == `PNL_FN_START);
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            led_cnt_q <= 6'h00;
            led_o     <= 1'b0;
        end else begin
            if (fire_w) begin
                led_cnt_q <= sw_time_q.led;
            end else if (tick_w && led_cnt_q != 6'h00) begin
                led_cnt_q <= led_cnt_q - 6'h01;
            end
            led_o <= fire_w ? (sw_time_q.led != 6'h00) : (led_cnt_q != 6'h00);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Differential outputs.

    logic [31:0] qpos_q;
    logic        qinit_q;
    logic [7:0]  qgap_q;
    logic [15:0] offa_q;
    logic [15:0] offb_q;
    logic        sig_a_w;
    logic        sig_b_w;
    logic        held_a_w;
    logic        held_b_w;

    function automatic logic pnl_pick(input logic [127:0] bus, input logic [7:0] code);
        pnl_pick = code[7] ? 1'b0 : bus[code[6:0]];
    endfunction

    assign sig_a_w = pnl_pick(io_status_i, sel_q.sel_a);
    assign sig_b_w = pnl_pick(io_status_i, sel_q.sel_b);

    // The off delay holds the selected signal before inversion.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            offa_q <= 16'h0000;
            offb_q <= 16'h0000;
        end else begin
            if (sig_a_w) begin
                offa_q <= dly_a_q;
            end else if (ms_w && offa_q != 16'h0000) begin
                offa_q <= offa_q - 16'h0001;
            end
            if (sig_b_w) begin
                offb_q <= dly_b_q;
            end else if (ms_w && offb_q != 16'h0000) begin
                offb_q <= offb_q - 16'h0001;
            end
        end
    end

    assign held_a_w = sig_a_w || (offa_q != 16'h0000);
    assign held_b_w = sig_b_w || (offb_q != 16'h0000);

    // One quadrature state per motor count keeps resolution tied to the
    // position scale; fast moves are spread out at one edge per QUAD_GAP.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            qinit_q <= 1'b1;
            qpos_q  <= 32'h00000000;
            qgap_q  <= 8'h00;
        end else if (qinit_q) begin
            qinit_q <= 1'b0;
            qpos_q  <= feedback_pos_i;
        end else if (qgap_q != 8'h00) begin
            qgap_q <= qgap_q - 8'h01;
        end else if (qpos_q != feedback_pos_i) begin
            qgap_q <= 8'(QUAD_GAP - 1);
            if ($signed(feedback_pos_i - qpos_q) > 0) begin
                qpos_q <= qpos_q + 32'h00000001;
            end else begin
                qpos_q <= qpos_q - 32'h00000001;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            diff_channel_a_o <= 1'b0;
            diff_channel_b_o <= 1'b0;
            diff_oe_o        <= 1'b0;
        end else begin
            case (mode_q)
                `PNL_MODE_QUAD: begin
                    diff_channel_a_o <= qpos_q[0] ^ qpos_q[1];
                    diff_channel_b_o <= qpos_q[1];
                    diff_oe_o        <= 1'b1;
                end
                `PNL_MODE_IO: begin
                    diff_channel_a_o <= held_a_w ^ sel_q.inv_a;
                    diff_channel_b_o <= held_b_w ^ sel_q.inv_b;
                    diff_oe_o        <= 1'b1;
                end
                default: begin
                    diff_channel_a_o <= 1'b0;
                    diff_channel_b_o <= 1'b0;
                    diff_oe_o        <= 1'b0;
                end
            endcase
        end
    end

    assign status_w = {24'h000000, diff_oe_o, diff_channel_b_o, diff_channel_a_o,
                       led_o, (lock_q == PNL_HOLDING), open_w, pressed_q, sw_sync_q};

endmodule
`default_nettype wire
